// ### hw/cis_core.sv
// cis_core: decode and execute slice of the core: loads, stores, jumps, add, coprocessors
// assumes: one clock, memory answers with mem_done, translation result same cycle
// Overview of operation
// RULE1: load-use hazard stalls next instruction one cycle
// RULE2: size code 0..7 means code+1 bytes
// RULE3: address names lowest-addressed byte always
// RULE4: lanes from size, low address bits, order
// RULE5: loads go to cache/memory, allocate if cacheable
// RULE6: translation miss raises miss exception
// RULE7: jumps and branches have one delay slot
// RULE8: software keeps jumps out of delay slots
// RULE9: delay-slot fault saves preceding jump address
// RULE10: software avoids link register as source
// RULE11: unaligned register jump faults at target fetch
// RULE12: four units, two spaces of 32 registers
// RULE13: general space memory-loadable, control space transfer-only
// RULE14: system coprocessor reached by transfers only
// RULE15: signed add sums sources, sign-extends result; code zero-extends it when mode64 is clear
// RULE16: overflow traps and leaves destination unchanged
// RULE17: software gives sign-extended add operands
// RULE18: register zero reads zero, ignores writes
// RULE19: effective order is memory order xor flip
// RULE20: signed add decoded by opcode, function, shift
// RULE21: faulting instruction updates nothing
`timescale 1ns/1ps
`default_nettype none
`include "cis_defines.svh"
module cis_core (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // mode
    input wire logic memory_byte_order,
    input wire logic user_mode,
    input wire logic user_flip_enable,
    input wire logic mode64,
    input wire logic cache_enable,
    // instruction stream
    input wire logic [31:0] instr,
    input wire logic instr_valid,
    output logic instr_ready,
    output logic [63:0] fetch_pc,
    // translation
    input wire logic xlat_hit,
    input wire logic [63:0] xlat_paddr,
    // memory
    output cis_pkg::cis_mem_req_t mem_req,
    output logic mem_cacheable,
    input wire logic mem_done,
    input wire logic [63:0] mem_rdata,
    // coprocessors
    output cis_pkg::cis_cop_req_t cop_req,
    input wire logic [31:0] cop_rdata,
    // exceptions and effective byte order
    output logic exc_valid,
    output logic [2:0] exc_code,
    output logic [63:0] exception_return_address,
    output logic effective_byte_order
);
    import cis_pkg::*;
    logic [63:0] integer_register_file [0:31];
    cis_state_t state_r;
    logic [63:0] pc_r, npc_r, prev_pc_r;
    logic in_slot_r, target_bad_r, loadpend_r, jr_bad_r;
    logic [4:0] load_dst_r, mem_dst_r;
    logic mem_cop_r, mem_signed_r;
    logic [31:0] ir;
    logic [5:0] op, fn;
    logic [4:0] fs, ss, rd, sa;
    logic [63:0] va, vs, vt, imm, sum64, lane_val;
    logic [32:0] sum33;
    logic is_add, is_ld, is_st, is_jr, is_j, is_br, is_cop, is_cmem, ovf, stall, take, exc;
    logic [2:0] size, ecode;
    logic [7:0] lanes;
    logic misfit;
    cis_access_t acc;

    function automatic logic [63:0] rd_reg(input logic [4:0] idx);
        rd_reg = (idx == 5'h00) ? 64'h0 : integer_register_file[idx]; // [RULE18]
    endfunction
    function automatic logic [63:0] sx32(input logic [31:0] v);
        sx32 = {{32{v[31]}}, v};
    endfunction

    assign ir = instr;
    assign op = ir[31:`CIS_OP_LSB];
    assign fs = ir[25:`CIS_FS_LSB];
    assign ss = ir[20:`CIS_SS_LSB];
    assign rd = ir[15:`CIS_RD_LSB];
    assign sa = ir[10:`CIS_SA_LSB];
    assign fn = ir[5:0];
    assign vs = rd_reg(fs);
    assign vt = rd_reg(ss);
    assign imm = {{48{ir[15]}}, ir[15:0]};
    assign effective_byte_order = memory_byte_order ^ (user_mode & user_flip_enable); // [RULE19]

    always_comb begin
        is_add = (op == `CIS_OP_SPECIAL) && (fn == `CIS_FN_ADD) && (sa == 5'h00); // [RULE20]
        is_jr = (op == `CIS_OP_SPECIAL) && (fn == `CIS_FN_JR || fn == `CIS_FN_JALR);
        is_j = (op == `CIS_OP_J) || (op == `CIS_OP_JAL);
        is_br = (op == `CIS_OP_BEQ) || (op == `CIS_OP_BNE);
        is_ld = (op == `CIS_OP_LB) || (op == `CIS_OP_LW) || (op == `CIS_OP_LD);
        is_st = (op == `CIS_OP_SB) || (op == `CIS_OP_SW) || (op == `CIS_OP_SD);
        is_cop = (op[5:2] == 4'h4) && (fs == `CIS_COP_MF || fs == `CIS_COP_CF ||
                 fs == `CIS_COP_MT || fs == `CIS_COP_CT); // [RULE12] [RULE13]
        // memory path to general space of units 1..3 only [RULE13] [RULE14]
        is_cmem = (op[5:3] == 3'h6 || op[5:3] == 3'h7) && op[2] == 1'b0
                  && op[1:0] != 2'h0;
        unique case (op)
            `CIS_OP_LB, `CIS_OP_SB: size = `CIS_SZ_BYTE;
            `CIS_OP_LD, `CIS_OP_SD: size = `CIS_SZ_DWORD;
            default: size = `CIS_SZ_WORD;
        endcase
    end

    assign va = vs + imm;
    assign acc = '{size: size, addr_lo: va[2:0], big_endian: effective_byte_order};
    cis_lane_dec u_lanes (
        .acc(acc),
        .lanes(lanes),
        .misfit(misfit)
    );

    // signed add with overflow from the 30/31 carries [RULE15] [RULE16]
    assign sum33 = {vs[31], vs[31:0]} + {vt[31], vt[31:0]};
    assign ovf = sum33[32] ^ sum33[31];
    assign sum64 = mode64 ? sx32(sum33[31:0]) : {32'h0, sum33[31:0]};

    // load-use interlock, one pipeline cycle [RULE1]
    // counted once memory has answered, so the wait cannot hide it
    assign stall = loadpend_r && (state_r == CIS_RUN) && instr_valid && (load_dst_r != 5'h00)
                   && (fs == load_dst_r || ss == load_dst_r);
    assign take = (state_r == CIS_RUN) && instr_valid && !stall;

    always_comb begin
        ecode = `CIS_EXC_NONE;
        if (target_bad_r) begin
            ecode = `CIS_EXC_ADDR; // [RULE11]
        end else if (is_add && ovf) begin
            ecode = `CIS_EXC_OVF;
        end else if ((is_ld || is_st || is_cmem) && !xlat_hit) begin
            ecode = `CIS_EXC_TMISS; // [RULE6]
        end else if ((is_ld || is_st || is_cmem) && (misfit || (va[2:0] & size) != 3'h0)) begin
            ecode = `CIS_EXC_ADDR;
        end else if (op == `CIS_OP_LWC0 || op == `CIS_OP_SWC0) begin
            ecode = `CIS_EXC_RI; // [RULE14]
        end
    end
    assign exc = take && (ecode != `CIS_EXC_NONE);

    assign instr_ready = take;
    assign fetch_pc = pc_r;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r <= CIS_RUN;
        end else begin
            unique case (state_r)
                CIS_RUN: if (take && !exc && (is_ld || is_st || is_cmem)) state_r <= CIS_MEMW;
                CIS_MEMW: if (mem_done) state_r <= CIS_RUN;
                CIS_STALL: state_r <= CIS_RUN;
            endcase
        end
    end

    // program counter and delay slot [RULE7]
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pc_r <= `CIS_PC_RESET;
            npc_r <= `CIS_PC_RESET + 64'h4;
            prev_pc_r <= `CIS_PC_RESET;
            in_slot_r <= 1'b0;
            target_bad_r <= 1'b0;
        end else if (exc) begin
            pc_r <= `CIS_PC_RESET;
            npc_r <= `CIS_PC_RESET + 64'h4;
            in_slot_r <= 1'b0;
            target_bad_r <= 1'b0;
        end else if (take) begin
            prev_pc_r <= pc_r;
            pc_r <= npc_r;
            in_slot_r <= is_j || is_jr || is_br;
            target_bad_r <= in_slot_r && jr_bad_r; // [RULE11]
            npc_r <= npc_r + 64'h4;
            if (is_jr) begin
                npc_r <= vs;
                target_bad_r <= 1'b0;
            end else if (is_j) begin
                npc_r <= {npc_r[63:28], ir[25:0], 2'b00};
            end else if (is_br && ((op == `CIS_OP_BEQ) == (vs == vt))) begin
                npc_r <= npc_r + {imm[61:0], 2'b00};
            end
        end
    end

    // unaligned register jump is flagged when its target is fetched [RULE11]
    always_ff @(posedge clk) begin
        if (!rstn || exc) begin
            jr_bad_r <= 1'b0;
        end else if (take) begin
            jr_bad_r <= is_jr && (vs[1:0] != 2'b00);
        end
    end

    // exception report and return address [RULE9]
    always_ff @(posedge clk) begin
        if (!rstn) begin
            exc_valid <= 1'b0;
            exc_code <= `CIS_EXC_NONE;
            exception_return_address <= 64'h0;
        end else begin
            exc_valid <= exc;
            if (exc) begin
                exc_code <= ecode;
                exception_return_address <= in_slot_r ? prev_pc_r : pc_r;
            end
        end
    end

    // memory request, cache allocate follows cache enable [RULE5]
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mem_req <= '0;
            mem_cacheable <= 1'b0;
            mem_dst_r <= 5'h00;
            mem_cop_r <= 1'b0;
            mem_signed_r <= 1'b0;
        end else if (take && !exc && (is_ld || is_st || is_cmem)) begin
            mem_req.valid <= 1'b1; // [RULE21]
            mem_req.write <= is_st || (is_cmem && op[3]);
            mem_req.addr <= xlat_paddr;
            mem_req.size <= size;
            mem_req.lanes <= lanes; // [RULE4]
            mem_req.wdata <= vt << {va[2:0], 3'b000};
            mem_req.cop_path <= is_cmem;
            mem_cacheable <= cache_enable;
            mem_dst_r <= ss;
            mem_cop_r <= is_cmem;
            mem_signed_r <= 1'b1;
        end else if (mem_done) begin
            mem_req.valid <= 1'b0;
        end
    end

    always_comb begin
        lane_val = mem_rdata >> {mem_req.addr[2:0], 3'b000};
        unique case (mem_req.size)
            `CIS_SZ_BYTE: lane_val = {{56{lane_val[7]}}, lane_val[7:0]};
            `CIS_SZ_WORD: lane_val = sx32(lane_val[31:0]);
            default: lane_val = lane_val;
        endcase
    end

    // coprocessor transfers to either space [RULE13]
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cop_req <= '0;
        end else begin
            cop_req.valid <= take && !exc && is_cop;
            cop_req.unit <= op[1:0];
            cop_req.ctrl <= fs[1];
            cop_req.write <= fs[2];
            cop_req.index <= rd;
            cop_req.data <= vt[31:0];
        end
    end

    // load pending flag for the interlock [RULE1]
    always_ff @(posedge clk) begin
        if (!rstn) begin
            loadpend_r <= 1'b0;
            load_dst_r <= 5'h00;
        end else if (take) begin
            loadpend_r <= is_ld && !exc;
            load_dst_r <= ss;
        end else if (stall) begin
            loadpend_r <= 1'b0;
        end
    end

    // register file writes; register zero never written [RULE18] [RULE16] [RULE21]
    always_ff @(posedge clk) begin
        if (take && !exc && is_add && rd != 5'h00) begin
            integer_register_file[rd] <= sum64; // [RULE15]
        end else if (take && !exc && is_cop && !fs[2] && ss != 5'h00) begin
            integer_register_file[ss] <= sx32(cop_rdata);
        end else if (state_r == CIS_MEMW && mem_done && !mem_req.write && !mem_cop_r
                     && mem_dst_r != 5'h00) begin
            integer_register_file[mem_dst_r] <= lane_val;
        end
    end

    property p_ovf_keep;
        @(posedge clk) disable iff (!rstn)
        (take && is_add && ovf) |=> exc_valid && exc_code == `CIS_EXC_OVF;
    endproperty
    a_ovf_keep: assert property (p_ovf_keep) else $error("overflow not reported"); // [RULE16]
    property p_stall_one;
        @(posedge clk) disable iff (!rstn)
        stall |=> !stall;
    endproperty
    a_stall_one: assert property (p_stall_one) else $error("interlock longer than one"); // [RULE1]
    property p_order;
        @(posedge clk) disable iff (!rstn)
        effective_byte_order == (memory_byte_order ^ (user_mode & user_flip_enable));
    endproperty
    a_order: assert property (p_order) else $error("byte order wrong"); // [RULE19]
    property p_miss;
        @(posedge clk) disable iff (!rstn)
        (take && is_ld && !xlat_hit) |=> exc_code == `CIS_EXC_TMISS && !mem_req.valid;
    endproperty
    a_miss: assert property (p_miss) else $error("miss not raised"); // [RULE6]
    property p_slot_ret;
        @(posedge clk) disable iff (!rstn)
        (exc && in_slot_r) |=> exception_return_address == $past(prev_pc_r);
    endproperty
    a_slot_ret: assert property (p_slot_ret) else $error("slot return address wrong"); // [RULE9]
    property p_nocp0mem;
        @(posedge clk) disable iff (!rstn)
        (take && op == `CIS_OP_LWC0) |=> !mem_req.valid || $past(mem_req.valid);
    endproperty
    a_nocp0mem: assert property (p_nocp0mem) else $error("system coprocessor memory path used"); // [RULE14]
    property p_cache;
        @(posedge clk) disable iff (!rstn)
        $rose(mem_req.valid) |-> mem_cacheable == $past(cache_enable);
    endproperty
    a_cache: assert property (p_cache) else $error("allocate flag wrong"); // [RULE5]
    property p_zero;
        @(posedge clk) disable iff (!rstn)
        rd_reg(5'h00) == 64'h0;
    endproperty
    a_zero: assert property (p_zero) else $error("register zero nonzero"); // [RULE18]
endmodule
`default_nettype wire

// ### hw/cis_defines.svh
// cis_defines.svh: offsets, field positions, opcodes and codes of the core slice
// assumes: included by bare name from the package and the design files
`ifndef CIS_DEFINES_SVH
`define CIS_DEFINES_SVH
`define CIS_OP_LSB 26
`define CIS_FS_LSB 21
`define CIS_SS_LSB 16
`define CIS_RD_LSB 11
`define CIS_SA_LSB 6
`define CIS_OP_SPECIAL 6'h00
`define CIS_FN_ADD 6'h20
`define CIS_FN_JR 6'h08
`define CIS_FN_JALR 6'h09
`define CIS_OP_J 6'h02
`define CIS_OP_JAL 6'h03
`define CIS_OP_BEQ 6'h04
`define CIS_OP_BNE 6'h05
`define CIS_OP_LD 6'h37
`define CIS_OP_SD 6'h3F
`define CIS_OP_LW 6'h23
`define CIS_OP_SW 6'h2B
`define CIS_OP_LB 6'h20
`define CIS_OP_SB 6'h28
`define CIS_OP_COP0 6'h10
`define CIS_OP_LWC0 6'h30
`define CIS_OP_SWC0 6'h38
`define CIS_COP_MF 5'h00
`define CIS_COP_CF 5'h02
`define CIS_COP_MT 5'h04
`define CIS_COP_CT 5'h06
`define CIS_SZ_BYTE 3'h0
`define CIS_SZ_WORD 3'h3
`define CIS_SZ_DWORD 3'h7
`define CIS_EXC_NONE 3'h0
`define CIS_EXC_OVF 3'h1
`define CIS_EXC_TMISS 3'h2
`define CIS_EXC_ADDR 3'h3
`define CIS_EXC_RI 3'h4
`define CIS_PC_RESET 64'hFFFFFFFFBFC00000
`define CIS_STALL_CYC 1
`endif

// ### hw/cis_pkg.sv
// cis_pkg: types shared by the core slice and its lane decoder
// assumes: cis_defines.svh on the include path
`include "cis_defines.svh"
package cis_pkg;
    typedef struct packed {
        logic [2:0] size;     // bytes minus one
        logic [2:0] addr_lo;
        logic big_endian;
    } cis_access_t;
    typedef struct packed {
        logic valid;
        logic [1:0] unit;
        logic ctrl;           // control space when set
        logic write;
        logic [4:0] index;
        logic [31:0] data;
    } cis_cop_req_t;
    typedef struct packed {
        logic valid;
        logic write;
        logic [63:0] addr;
        logic [2:0] size;
        logic [7:0] lanes;
        logic [63:0] wdata;
        logic cop_path;
    } cis_mem_req_t;
    typedef enum logic [2:0] {
        CIS_RUN = 3'b001,
        CIS_MEMW = 3'b010,
        CIS_STALL = 3'b100
    } cis_state_t;
endpackage

// ### hw/cis_lane_dec.sv
// cis_lane_dec: byte lanes of a doubleword from size code, low address and order
// assumes: combinational, used inside the core slice
`timescale 1ns/1ps
`default_nettype none
module cis_lane_dec (
    // access
    input wire cis_pkg::cis_access_t acc,
    // lanes, bit i is byte lane i of the doubleword: memory byte i in little order, memory byte 7-i in big order
    output logic [7:0] lanes,
    output logic misfit
);
    import cis_pkg::*;
    logic [3:0] last;
    logic [7:0] mask;
    always_comb begin
        last = {1'b0, acc.addr_lo} + {1'b0, acc.size};
        mask = 8'hFF >> (4'h7 - {1'b0, acc.size}); // [RULE2]
        misfit = last[3];
        // address names the lowest byte in either order [RULE3] [RULE4]
        lanes = mask << acc.addr_lo;
        if (acc.big_endian) begin
            lanes = mask << (3'h7 - 3'(acc.addr_lo + acc.size));
        end
    end
endmodule
`default_nettype wire

// ### sim/cis_mem_model.sv
// cis_mem_model: cache, memory and coprocessor stand-in for the core slice
// assumes: bench sets answer delay and data while no request is open
`timescale 1ns/1ps
`default_nettype none
module cis_mem_model (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // requests
    input wire cis_pkg::cis_mem_req_t mem_req,
    input wire cis_pkg::cis_cop_req_t cop_req,
    // bench control
    input wire logic [2:0] delay,
    input wire logic [63:0] load_data,
    input wire logic [31:0] cop_data,
    // answers
    output logic mem_done,
    output logic [63:0] mem_rdata,
    output logic [31:0] cop_rdata
);
    import cis_pkg::*;
    logic [2:0] cnt_r;
    // read data is taken with the move-from itself; inverse while a write pulse is out
    assign cop_rdata = (cop_req.valid && cop_req.write) ? ~cop_data : cop_data;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_r <= 3'h0;
            mem_done <= 1'b0;
            mem_rdata <= 64'h0;
        end else begin
            mem_done <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req.valid && !mem_done) begin
                cnt_r <= (cnt_r == delay) ? 3'h0 : cnt_r + 3'h1;
                if (cnt_r == delay) begin
                    mem_done <= 1'b1;
                    mem_rdata <= load_data;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/cis_core_tb.sv
// cis_core_tb: self-checking bench of the core slice against a memory stand-in
// assumes: cis_pkg, cis_core and cis_mem_model compiled first
`timescale 1ns/1ps
`default_nettype none
`include "cis_defines.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end
module cis_core_tb;
    import cis_pkg::*;
    localparam logic [31:0] NOP = 32'h00000020;
    logic clk, rstn, memory_byte_order, user_mode, user_flip_enable, cache_enable, m64;
    logic instr_valid, instr_ready, xlat_hit, mem_cacheable, mem_done, exc_valid, ebo, cach_l;
    logic [31:0] instr, cop_rdata, cop_data, lfsr_r;
    logic [63:0] fetch_pc, xlat_paddr, mem_rdata, era, load_data, pc_v, era_l;
    logic [2:0] exc_code, delay, exc_l;
    cis_mem_req_t mem_req, mreq_l;
    cis_cop_req_t cop_req, cop_l;
    int fails = 0, cmp_count = 0, cyc = 0, exc_n = 0, mreq_n = 0, t_v;
    cis_core dut (.clk(clk), .rstn(rstn), .memory_byte_order(memory_byte_order),
        .user_mode(user_mode), .user_flip_enable(user_flip_enable), .mode64(m64),
        .cache_enable(cache_enable), .instr(instr), .instr_valid(instr_valid),
        .instr_ready(instr_ready), .fetch_pc(fetch_pc), .xlat_hit(xlat_hit),
        .xlat_paddr(xlat_paddr), .mem_req(mem_req), .mem_cacheable(mem_cacheable),
        .mem_done(mem_done), .mem_rdata(mem_rdata), .cop_req(cop_req),
        .cop_rdata(cop_rdata), .exc_valid(exc_valid), .exc_code(exc_code),
        .exception_return_address(era), .effective_byte_order(ebo));
    cis_mem_model mem (.clk(clk), .rstn(rstn), .mem_req(mem_req), .cop_req(cop_req),
        .delay(delay), .load_data(load_data), .cop_data(cop_data), .mem_done(mem_done),
        .mem_rdata(mem_rdata), .cop_rdata(cop_rdata));
    // captures one-cycle answers for later comparison
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (exc_valid === 1'b1) begin
            exc_n <= exc_n + 1;
            exc_l <= exc_code;
            era_l <= era;
        end
        if (cop_req.valid === 1'b1) cop_l <= cop_req;
        if (mem_req.valid === 1'b1 && mem_done === 1'b1) begin
            mreq_n <= mreq_n + 1;
            mreq_l <= mem_req;
            cach_l <= mem_cacheable;
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] lanes_exp(input logic [2:0] sz, input logic [2:0] a,
        input logic be);
        logic [15:0] m;
        logic [7:0] r;
        m = ((16'h0001 << (sz + 1)) - 16'h0001) << a;
        // big order puts the lowest address in the most significant lane
        for (int i = 0; i < 8; i++) r[i] = be ? m[7 - i] : m[i];
        return r;
    endfunction
    function automatic logic [63:0] sx(input logic [31:0] v);
        return {{32{v[31]}}, v};
    endfunction
    function automatic logic [31:0] enc(input logic [5:0] op, input logic [4:0] a,
        input logic [4:0] b, input logic [15:0] imm);
        return {op, a, b, imm};
    endfunction
    function automatic logic [31:0] add_i(input logic [4:0] d, input logic [4:0] s,
        input logic [4:0] t);
        return enc(`CIS_OP_SPECIAL, s, t, {d, 5'h00, `CIS_FN_ADD});
    endfunction
    function automatic logic cur_be();
        return memory_byte_order ^ (user_mode & user_flip_enable);
    endfunction
    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic issue(input logic [31:0] ins);
        int i;
        instr <= ins;
        instr_valid <= 1'b1;
        for (i = 0; i < 300; i++) begin
            @(negedge clk);
            if (instr_ready === 1'b1) break;
        end
        if (i == 300) begin
            fails++;
            end_sim();
        end else begin
            pc_v = fetch_pc;
            t_v = cyc;
            @(posedge clk);
        end
    endtask
    task automatic nops(input int n);
        repeat (n) issue(NOP);
    endtask
    // access through register zero base at offset 0x100 plus a
    task automatic mem_op(input logic [5:0] op, input logic [4:0] dst, input logic [2:0] a,
        input logic [2:0] sz, input logic wr, input logic be);
        int n0;
        n0 = mreq_n;
        xlat_paddr <= {52'h0, 9'h010, a};
        issue(enc(op, 5'h00, dst, {13'h0020, a}));
        nops(2);
        `CHK("mem count", n0 + 1, mreq_n)
        `CHK("size", sz, mreq_l.size)
        `CHK("lanes", lanes_exp(sz, a, be), mreq_l.lanes)
        `CHK("addr lo", a, mreq_l.addr[2:0])
        `CHK("write", wr, mreq_l.write)
        if (!wr) `CHK("cacheable", cache_enable, cach_l)
    endtask
    task automatic ld(input logic [4:0] r, input logic [63:0] v);
        load_data <= v;
        mem_op(`CIS_OP_LD, r, 3'h0, 3'h7, 1'b0, cur_be());
    endtask
    task automatic rd(input logic [4:0] r);
        mem_op(`CIS_OP_SD, r, 3'h0, 3'h7, 1'b1, cur_be());
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        logic [31:0] a, b, s;
        logic [63:0] old, pb;
        logic ovf, be;
        logic [2:0] ad;
        int t0, t1, e0, n0;
        {rstn, instr_valid, memory_byte_order, user_mode, user_flip_enable} = 5'h00;
        {m64, cache_enable, xlat_hit, instr, xlat_paddr, delay} = {3'b111, NOP, 64'h0, 3'h1};
        {load_data, cop_data, lfsr_r} = {64'h0, 32'h0, 32'h00000047};
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            lfsr_r = lfsr(lfsr_r);
            {memory_byte_order, user_mode, user_flip_enable} <= k[2:0];
            {cache_enable, delay} <= lfsr_r[3:0];
            ad = lfsr_r[6:4];
            @(negedge clk);
            be = k[2] ^ (k[1] & k[0]);
            `CHK("order", be, ebo)
            @(posedge clk);
            mem_op(`CIS_OP_LB, 5'h09, ad, `CIS_SZ_BYTE, 1'b0, be);
            mem_op(`CIS_OP_SB, 5'h09, ad, `CIS_SZ_BYTE, 1'b1, be);
            mem_op(`CIS_OP_LW, 5'h09, {ad[2], 2'b00}, `CIS_SZ_WORD, 1'b0, be);
            mem_op(`CIS_OP_SW, 5'h09, {ad[2], 2'b00}, `CIS_SZ_WORD, 1'b1, be);
            mem_op(`CIS_OP_LD, 5'h09, 3'h0, `CIS_SZ_DWORD, 1'b0, be);
            mem_op(`CIS_OP_SD, 5'h09, 3'h0, `CIS_SZ_DWORD, 1'b1, be);
        end
        for (int k = 0; k < 12; k++) begin
            lfsr_r = lfsr(lfsr_r);
            a = (k == 0) ? 32'h7FFFFFFF : (k == 1) ? 32'h80000000 : lfsr_r;
            lfsr_r = lfsr(lfsr_r);
            b = (k == 0) ? 32'h00000001 : (k == 1) ? 32'hFFFFFFFF : lfsr_r;
            old = sx(lfsr_r ^ 32'h5A5A5A5A);
            m64 <= (k != 2);
            ld(5'h01, sx(a));
            ld(5'h02, sx(b));
            ld(5'h03, old);
            e0 = exc_n;
            issue(add_i(5'h03, 5'h01, 5'h02));
            pb = pc_v;
            nops(2);
            s = a + b;
            ovf = (a[31] == b[31]) && (s[31] != a[31]);
            `CHK("ovf count", e0 + ovf, exc_n)
            if (ovf) `CHK("ovf code", `CIS_EXC_OVF, exc_l)
            if (ovf) `CHK("ovf return", pb, era_l)
            rd(5'h03);
            `CHK("sum", ovf ? old : (m64 ? sx(s) : {32'h0, s}), mreq_l.wdata)
        end
        issue(add_i(5'h00, 5'h01, 5'h02));
        ld(5'h00, 64'h00000000000000FF);
        rd(5'h00);
        `CHK("zero reg", 64'h0, mreq_l.wdata)
        delay <= 3'h2;
        for (int k = 0; k < 2; k++) begin
            issue(enc(`CIS_OP_LD, 5'h00, 5'h04, 16'h0100));
            t0 = t_v;
            issue(add_i(5'h05, k ? 5'h04 : 5'h02, 5'h02));
            if (k) `CHK("use stall", t1 + `CIS_STALL_CYC, t_v - t0)
            t1 = t_v - t0;
        end
        ld(5'h02, 64'h1);
        for (int k = 0; k < 2; k++) begin
            ld(5'h01, sx(k ? 32'h7FFFFFFF : 32'h00000005));
            e0 = exc_n;
            issue(enc(`CIS_OP_BEQ, 5'h00, 5'h00, 16'h0004));
            pb = pc_v;
            issue(add_i(5'h06, 5'h01, 5'h02));
            `CHK("slot pc", pb + 4, pc_v)
            issue(NOP);
            if (!k) `CHK("target pc", pb + 20, pc_v)
            nops(2);
            `CHK("slot exc", e0 + k, exc_n)
            if (k) `CHK("slot return", pb, era_l)
        end
        for (int k = 0; k < 2; k++) begin
            ld(5'h07, 64'hFFFFFFFFBFC01000 + 2 * k);
            e0 = exc_n;
            issue(enc(`CIS_OP_SPECIAL, 5'h07, 5'h00, {10'h000, `CIS_FN_JR}));
            nops(2);
            if (!k) `CHK("jr target", 64'hFFFFFFFFBFC01000, pc_v)
            nops(2);
            `CHK("jr fault", e0 + k, exc_n)
            if (k) `CHK("jr code", `CIS_EXC_ADDR, exc_l)
        end
        ld(5'h03, 64'h0000000000000077);
        load_data <= 64'h0000000000000099;
        xlat_hit <= 1'b0;
        {e0, n0} = {exc_n, mreq_n};
        issue(enc(`CIS_OP_LD, 5'h00, 5'h03, 16'h0100));
        nops(2);
        xlat_hit <= 1'b1;
        `CHK("miss code", `CIS_EXC_TMISS, exc_l)
        `CHK("miss mem", n0, mreq_n)
        issue(add_i(5'h03, 5'h01, 5'h02) | 32'h00000040);
        rd(5'h03);
        `CHK("kept reg", 64'h0000000000000077, mreq_l.wdata)
        for (int k = 0; k < 2; k++) begin
            {e0, n0} = {exc_n, mreq_n};
            issue(enc(k ? `CIS_OP_SWC0 : `CIS_OP_LWC0, 5'h00, 5'h03, 16'h0100));
            nops(2);
            `CHK("cop0 mem", n0, mreq_n)
            `CHK("cop0 code", `CIS_EXC_RI, exc_l)
        end
        for (int k = 0; k < 4; k++) begin
            lfsr_r = lfsr(lfsr_r);
            cop_data <= lfsr_r;
            issue(enc(`CIS_OP_COP0, {2'b00, ~k[1], k[0], 1'b0}, k[1] ? 5'h08 : 5'h01,
                {lfsr_r[4:0], 11'h000}));
            nops(2);
            `CHK("cop ctrl", k[0], cop_l.ctrl)
            `CHK("cop write", ~k[1], cop_l.write)
            `CHK("cop index", lfsr_r[4:0], cop_l.index)
            if (!k[1]) `CHK("cop wdata", 32'h7FFFFFFF, cop_l.data)
            if (k[1]) rd(5'h08);
            if (k[1]) `CHK("cop read", lfsr_r, mreq_l.wdata[31:0])
        end
        mem_op(`CIS_OP_LWC0 | 6'h01, 5'h09, 3'h4, `CIS_SZ_WORD, 1'b0, cur_be());
        `CHK("cop path", 1'b1, mreq_l.cop_path)
        end_sim();
    end
endmodule
`default_nettype wire
